// ### hw/usf_status_flags.sv
// Status flag logic of the serial transceiver with its register slave.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module usf_status_flags
  import usf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_load,
  input wire logic tx_busy,
  input wire logic rx_frame_start,
  input wire logic rx_sample_en,
  input wire logic rx_sample,
  input wire logic rx_bit_end,
  input wire logic rx_start_end,
  input wire logic rx_stop_end,
  input wire logic rx_char_done,
  input wire logic [8:0] rx_char,
  input wire logic rx_stop_bit,
  input wire logic rx_line,
  input wire logic bit_tick,
  output logic [7:0] tx_data,
  output logic tx_buffer_empty,
  output logic tx_enable,
  output logic break_queue,
  output logic ninth_bit_select
);

  logic [7:0] flags_q;
  logic [7:0] armed_q;
  logic [6:0] ctrl_q;
  logic [8:0] rx_buf_q;
  logic [7:0] tx_data_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic tx_idle_q;
  logic allow_q;
  logic [3:0] cnt_q;
  usf_quiet_t quiet_q;

  logic setup;
  logic access;
  logic hit_status;
  logic hit_data;
  logic hit_ctrl;
  logic map_hit;
  logic stat_rd;
  logic data_rd;
  logic data_wr;
  logic ctrl_wr;
  logic txen_rise;
  logic brk_wr;
  logic [7:0] clr;
  logic [7:0] set;
  logic [31:0] rd_mux;
  logic tx_idle;
  logic tc_set;
  logic rx_take;
  logic overrun;
  logic deliver;
  logic noise;
  logic [8:0] par_bits;
  logic par_err;
  logic [3:0] char_bits;
  logic [3:0] cnt_inc;
  logic start_cnt;
  logic quiet_stop;
  logic quiet_done;
  logic idle_set;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign hit_status = (paddr == USF_OFF_STATUS);
  assign hit_data = (paddr == USF_OFF_DATA);
  assign hit_ctrl = (paddr == USF_OFF_CTRL);
  assign map_hit = hit_status || hit_data || hit_ctrl;
  assign stat_rd = access && !pwrite && hit_status;
  assign data_rd = access && !pwrite && hit_data;
  assign data_wr = access && pwrite && hit_data;
  assign ctrl_wr = access && pwrite && hit_ctrl;
  assign txen_rise = ctrl_wr && pwdata[USF_CB_TXEN] && !ctrl_q[USF_CB_TXEN];
  assign brk_wr = ctrl_wr && pwdata[USF_CB_BREAK];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_status) begin
      rd_mux = {24'h00_0000, flags_q};
    end else if (hit_data) begin
      rd_mux = {23'h00_0000, rx_buf_q};
    end else if (hit_ctrl) begin
      rd_mux = {25'h000_0000, ctrl_q};
    end
  end

  // ********************************************************************
  // Bus answer
  // ********************************************************************
  // Answering in the first access cycle keeps every transfer exactly two cycles long.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !map_hit;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ********************************************************************
  // Control and data registers
  // ********************************************************************
  // A write at the status offset is accepted on the bus and discarded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= USF_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_q <= 8'h00;
    end else if (data_wr) begin
      tx_data_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 9'h000;
    end else if (deliver) begin
      rx_buf_q <= rx_char;
    end
  end

  // ********************************************************************
  // Clear sequences
  // ********************************************************************
  // The mask returned by the last status read decides what later accesses may clear.
  always_comb begin
    clr = 8'h00;
    if (data_rd) begin
      clr[5:0] = armed_q[5:0] & USF_RX_CLR_ALL;
    end
    clr[USF_B_TXE] = data_wr && armed_q[USF_B_TXE];
    clr[USF_B_TXC] = (data_wr || txen_rise || brk_wr) && armed_q[USF_B_TXC];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 8'h00;
    end else if (stat_rd) begin
      armed_q <= prdata_q[7:0];
    end else begin
      armed_q <= armed_q & ~clr;
    end
  end

  // ********************************************************************
  // Transmit events
  // ********************************************************************
  // Completion is taken on the edge into idle, so a clear is not undone before the shifter starts.
  assign tx_idle = flags_q[USF_B_TXE] && !tx_busy;
  assign tc_set = tx_idle && !tx_idle_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_idle_q <= 1'b1;
    end else begin
      tx_idle_q <= tx_idle;
    end
  end

  // ********************************************************************
  // Receive events
  // ********************************************************************
  usf_noise_check u_noise (
    .clk(pclk),
    .rst_n(presetn),
    .frame_start(rx_frame_start),
    .sample_en(rx_sample_en),
    .sample(rx_sample),
    .bit_end(rx_bit_end),
    .noise(noise)
  );

  assign rx_take = rx_char_done && !ctrl_q[USF_CB_LBRK];
  assign overrun = rx_take && flags_q[USF_B_RXF] && !clr[USF_B_RXF];
  assign deliver = rx_take && !overrun;
  assign par_bits = ctrl_q[USF_CB_NINTH] ? rx_char : {1'b0, rx_char[7:0]};
  assign par_err = ((^par_bits) != ctrl_q[USF_CB_PODD]);

  // ********************************************************************
  // Quiet line detector
  // ********************************************************************
  assign char_bits = ctrl_q[USF_CB_NINTH] ? USF_CHAR_BITS_9 : USF_CHAR_BITS_8;
  assign cnt_inc = 4'(cnt_q + 4'h1);
  assign start_cnt = ctrl_q[USF_CB_QAFTER] ? rx_stop_end : rx_start_end;
  assign quiet_stop = ctrl_q[USF_CB_QAFTER] && rx_frame_start;
  assign quiet_done = (quiet_q == USF_Q_COUNT) && !start_cnt && !quiet_stop && bit_tick
    && rx_line && (cnt_inc == char_bits);
  assign idle_set = quiet_done && allow_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= USF_Q_WAIT;
      cnt_q <= 4'h0;
    end else begin
      case (quiet_q)
        USF_Q_WAIT: begin
          if (start_cnt) begin
            quiet_q <= USF_Q_COUNT;
            cnt_q <= 4'h0;
          end
        end
        USF_Q_COUNT: begin
          if (start_cnt) begin
            cnt_q <= 4'h0;
          end else if (quiet_stop) begin
            quiet_q <= USF_Q_WAIT;
            cnt_q <= 4'h0;
          end else if (bit_tick) begin
            if (!rx_line) begin
              cnt_q <= 4'h0;
            end else if (quiet_done) begin
              quiet_q <= USF_Q_WAIT;
              cnt_q <= 4'h0;
            end else begin
              cnt_q <= cnt_inc;
            end
          end
        end
        default: begin
          quiet_q <= USF_Q_WAIT;
          cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // A frame that never reaches the data buffer would otherwise raise the flag again after each clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      allow_q <= 1'b0;
    end else if (deliver) begin
      allow_q <= 1'b1;
    end else if (idle_set) begin
      allow_q <= 1'b0;
    end
  end

  // ********************************************************************
  // Status flags
  // ********************************************************************
  always_comb begin
    set = 8'h00;
    set[USF_B_TXE] = tx_load;
    set[USF_B_TXC] = tc_set;
    set[USF_B_RXF] = deliver;
    set[USF_B_IDLE] = idle_set;
    set[USF_B_OVR] = overrun;
    set[USF_B_NOISE] = deliver && noise;
    set[USF_B_FRAME] = deliver && !rx_stop_bit;
    set[USF_B_PAR] = deliver && ctrl_q[USF_CB_PEN] && par_err;
  end

  // Sets win over clears so an event landing on a clear access is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= USF_STATUS_RST;
    end else begin
      flags_q <= (flags_q & ~clr) | set;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_data = tx_data_q;
  assign tx_buffer_empty = flags_q[USF_B_TXE];
  assign tx_enable = ctrl_q[USF_CB_TXEN];
  assign break_queue = ctrl_q[USF_CB_BREAK];
  assign ninth_bit_select = ctrl_q[USF_CB_NINTH];

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_status_write_ignored: assert property (
    (access && pwrite && hit_status && set == 8'h00) |=> (flags_q == $past(flags_q))
  ) else $error("status write changed a flag");

  a_load_sets_empty: assert property (
    tx_load |=> flags_q[USF_B_TXE] && tx_buffer_empty
  ) else $error("shifter load did not set transmit empty");

  // The next access ends two cycles after a read at the earliest, three with an idle cycle.
  a_empty_clear_seq: assert property (
    (stat_rd && prdata_q[USF_B_TXE]) ##[2:3] (data_wr && !tx_load && !stat_rd)
      |=> !flags_q[USF_B_TXE]
  ) else $error("transmit empty not cleared by read then write");

  a_complete_en_clear: assert property (
    (txen_rise && armed_q[USF_B_TXC] && !tc_set) |=> !flags_q[USF_B_TXC]
  ) else $error("enable rise did not clear transmit complete");

  a_full_on_deliver: assert property (
    (rx_char_done && !ctrl_q[USF_CB_LBRK] && !flags_q[USF_B_RXF])
      |=> flags_q[USF_B_RXF] && (rx_buf_q == $past(rx_char))
  ) else $error("character not moved into the data buffer");

  a_full_clear_seq: assert property (
    (data_rd && armed_q[USF_B_RXF] && !rx_char_done) |=> !flags_q[USF_B_RXF]
  ) else $error("receive full not cleared by read sequence");

  a_quiet_bound: assert property (
    (quiet_q == USF_Q_COUNT) |-> (cnt_q < char_bits)
  ) else $error("quiet counter passed the character time");

  a_quiet_once: assert property (
    ($rose(flags_q[USF_B_IDLE]) && !$past(deliver)) |-> !allow_q
  ) else $error("quiet flag left armed after setting");

  a_overrun_drops: assert property (
    overrun |=> flags_q[USF_B_OVR] && $stable(rx_buf_q) && flags_q[USF_B_RXF]
  ) else $error("overrun did not keep the old character");

  a_noise_with_full: assert property (
    (deliver && noise) |=> flags_q[USF_B_NOISE] && flags_q[USF_B_RXF]
  ) else $error("noise flag missed");

  a_frame_with_full: assert property (
    (deliver && !rx_stop_bit) |=> flags_q[USF_B_FRAME] && flags_q[USF_B_RXF]
  ) else $error("framing error flag missed");

  a_parity_error: assert property (
    (deliver && ctrl_q[USF_CB_PEN] && ((^par_bits) != ctrl_q[USF_CB_PODD]))
      |=> flags_q[USF_B_PAR]
  ) else $error("parity error flag missed");

  a_long_break_block: assert property (
    (rx_char_done && ctrl_q[USF_CB_LBRK] && !flags_q[USF_B_RXF])
      |=> !flags_q[USF_B_RXF] && $stable(rx_buf_q)
  ) else $error("long break detect let a character through");

  a_unarmed_kept: assert property (
    (data_rd && flags_q[USF_B_RXF] && !armed_q[USF_B_RXF]) |=> flags_q[USF_B_RXF]
  ) else $error("flag cleared without a status read");

  a_apb_answer: assert property (
    setup |=> pready ##1 !pready
  ) else $error("bus answer not in first access cycle");

  c_overrun: cover property (overrun);
  c_quiet_set: cover property (idle_set);
  c_break_clear: cover property (brk_wr && armed_q[USF_B_TXC]);
  c_parity_hit: cover property (set[USF_B_PAR]);

endmodule // usf_status_flags

// ### shared/usf_pkg.sv
// Constants shared by the serial status flag block.
// Contract
// - Status register read-only; writes do nothing.
// - Transmit-empty set at reset and on shifter load.
// - Status read then data write clears transmit-empty.
// - Transmit-complete set at reset and when idle.
// - Status read then data, enable-rise, break clears complete.
// - Receive-full set when character enters data buffer.
// - Status read then data read clears receive-full.
// - Quiet flag after 10 or 11 high bits.
// - Quiet count starts after start or stop bit.
// - Status read then data read clears quiet flag.
// - Quiet flag rearms only after a new character.
// - Overrun set and new character dropped when full.
// - Status read then data read clears overrun.
// - Disagreeing samples within a bit set noise.
// - Status read then data read clears noise.
// - Low stop bit sets framing error with full.
// - Status read then data read clears framing error.
// - Parity mismatch sets parity error when enabled.
// - Status read then data read clears parity error.
// - Long break detect blocks framing and receive-full.
// - Odd or even parity counts all ones.
package usf_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [11:0] USF_OFF_STATUS = 12'h000;
  localparam logic [11:0] USF_OFF_DATA = 12'h004;
  localparam logic [11:0] USF_OFF_CTRL = 12'h008;

  // ********************************************************************
  // Status bit positions and reset value
  // ********************************************************************
  localparam int USF_B_TXE = 7;
  localparam int USF_B_TXC = 6;
  localparam int USF_B_RXF = 5;
  localparam int USF_B_IDLE = 4;
  localparam int USF_B_OVR = 3;
  localparam int USF_B_NOISE = 2;
  localparam int USF_B_FRAME = 1;
  localparam int USF_B_PAR = 0;
  localparam logic [7:0] USF_STATUS_RST = 8'hC0;
  localparam logic [5:0] USF_RX_CLR_ALL = 6'h3F;

  // ********************************************************************
  // Control bit positions and reset value
  // ********************************************************************
  localparam int USF_CB_BREAK = 0;
  localparam int USF_CB_TXEN = 1;
  localparam int USF_CB_NINTH = 2;
  localparam int USF_CB_QAFTER = 3;
  localparam int USF_CB_PEN = 4;
  localparam int USF_CB_PODD = 5;
  localparam int USF_CB_LBRK = 6;
  localparam logic [6:0] USF_CTRL_RST = 7'h00;

  // ********************************************************************
  // Character times in bit times
  // ********************************************************************
  localparam logic [3:0] USF_CHAR_BITS_8 = 4'hA;
  localparam logic [3:0] USF_CHAR_BITS_9 = 4'hB;

  // ********************************************************************
  // Quiet line detector states
  // ********************************************************************
  typedef enum logic [0:0] {
    USF_Q_WAIT = 1'b0,
    USF_Q_COUNT = 1'b1
  } usf_quiet_t;

endpackage

// ### hw/usf_noise_check.sv
// Per-frame noise detector comparing samples within each bit time.
`timescale 1ns/1ps
module usf_noise_check
  import usf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_start,
  input wire logic sample_en,
  input wire logic sample,
  input wire logic bit_end,
  output logic noise
);

  logic have_q;
  logic ref_q;
  logic noise_q;

  // ********************************************************************
  // Sample comparison
  // ********************************************************************
  // The first sample of a bit is the reference; any later one that differs marks noise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      have_q <= 1'b0;
      ref_q <= 1'b0;
    end else if (frame_start || bit_end) begin
      have_q <= 1'b0;
    end else if (sample_en && !have_q) begin
      have_q <= 1'b1;
      ref_q <= sample;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      noise_q <= 1'b0;
    end else if (frame_start) begin
      noise_q <= 1'b0;
    end else if (sample_en && have_q && (sample != ref_q)) begin
      noise_q <= 1'b1;
    end
  end

  assign noise = noise_q;

endmodule // usf_noise_check

// ### tb/usf_line_model.sv
// Remote serial party model feeding receiver events to the flag block.
`timescale 1ns/1ps
module usf_line_model (
  input wire logic pclk,
  output logic rx_frame_start,
  output logic rx_sample_en,
  output logic rx_sample,
  output logic rx_bit_end,
  output logic rx_start_end,
  output logic rx_stop_end,
  output logic rx_char_done,
  output logic [8:0] rx_char,
  output logic rx_stop_bit,
  output logic rx_line,
  output logic bit_tick
);
  initial begin
    {rx_frame_start, rx_sample_en, rx_bit_end, rx_start_end} = 4'h0;
    {rx_stop_end, rx_char_done, bit_tick} = 3'h0;
    rx_sample = 1'b1;
    rx_line = 1'b1;
    rx_char = 9'h1FF;
    rx_stop_bit = 1'b0;
  end

  // ******************************************************************
  // Bit times and frames
  // ******************************************************************
  // One bit time of n samples; the last sample flips when bad is set.
  task automatic bit_time(input logic v, input int n, input logic bad);
    rx_line <= v;
    for (int i = 0; i < n; i++) begin
      rx_sample_en <= 1'b1;
      rx_sample <= (i == n - 1) ? v ^ bad : v;
      @(posedge pclk);
    end
    rx_sample_en <= 1'b0;
    rx_sample <= ~v;
    rx_bit_end <= 1'b1;
    bit_tick <= 1'b1;
    @(posedge pclk);
    rx_bit_end <= 1'b0;
    bit_tick <= 1'b0;
  endtask

  // Character data is only valid with its done pulse, so it is inverted after.
  task automatic send(input logic [8:0] c, input int nb, input logic stp, input logic bad);
    rx_frame_start <= 1'b1;
    @(posedge pclk);
    rx_frame_start <= 1'b0;
    bit_time(1'b0, 7, 1'b0);
    rx_start_end <= 1'b1;
    @(posedge pclk);
    rx_start_end <= 1'b0;
    for (int i = 0; i < nb; i++) bit_time(c[i], 3, bad && i == 0);
    bit_time(stp, 3, 1'b0);
    rx_stop_end <= 1'b1;
    rx_char_done <= 1'b1;
    rx_char <= c;
    rx_stop_bit <= stp;
    @(posedge pclk);
    {rx_stop_end, rx_char_done} <= 2'b00;
    rx_char <= ~c;
    rx_stop_bit <= ~stp;
  endtask

  task automatic idle(input int n);
    repeat (n) bit_time(1'b1, 3, 1'b0);
  endtask
endmodule // usf_line_model

// ### tb/test_usf_status_flags.sv
// Self-checking bench for the serial status flag block.
`timescale 1ns/1ps
module test_usf_status_flags;
  import usf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, tx_load = 1'b0, tx_busy = 1'b0;
  logic rx_frame_start, rx_sample_en, rx_sample, rx_bit_end, rx_start_end;
  logic rx_stop_end, rx_char_done, rx_stop_bit, rx_line, bit_tick;
  logic [8:0] rx_char;
  logic [7:0] tx_data;
  logic tx_buffer_empty, tx_enable, break_queue, ninth_bit_select;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  usf_status_flags dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_load, .tx_busy, .rx_frame_start, .rx_sample_en,
    .rx_sample, .rx_bit_end, .rx_start_end, .rx_stop_end, .rx_char_done, .rx_char,
    .rx_stop_bit, .rx_line, .bit_tick, .tx_data, .tx_buffer_empty, .tx_enable,
    .break_queue, .ninth_bit_select);

  usf_line_model lm (.pclk, .rx_frame_start, .rx_sample_en, .rx_sample, .rx_bit_end,
    .rx_start_end, .rx_stop_end, .rx_char_done, .rx_char, .rx_stop_bit, .rx_line,
    .bit_tick);

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  // Pready is read right after the edge, so the value before that edge is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 16) begin
        fail_count++;
        close_out();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rs(input logic [7:0] exp, input logic [7:0] m);
    apb(1'b0, USF_OFF_STATUS, 32'h0000_0000);
    check(rd & {24'h00_0000, m}, {24'h00_0000, exp & m}, "status");
  endtask

  task automatic drain;
    apb(1'b0, USF_OFF_STATUS, 32'h0000_0000);
    apb(1'b0, USF_OFF_DATA, 32'h0000_0000);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rs(8'hC0, 8'hFF);
    apb(1'b1, USF_OFF_STATUS, 32'h0000_00FF);
    rs(8'hC0, 8'hFF);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(err, 1'b1, "unmapped");
    rs(8'hC0, 8'hFF);
    apb(1'b1, USF_OFF_DATA, 32'h0000_005A);
    rs(8'h00, 8'hFF);
    check(tx_buffer_empty, 1'b0, "txempty");
    check(tx_data, 8'h5A, "txdata");
    tx_busy <= 1'b1;
    tx_load <= 1'b1;
    @(posedge pclk);
    tx_load <= 1'b0;
    rs(8'h80, 8'hFF);
    check(tx_buffer_empty, 1'b1, "txempty");
    tx_busy <= 1'b0;
    @(posedge pclk);
    rs(8'hC0, 8'hFF);
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0001);
    rs(8'h80, 8'hFF);
    check(break_queue, 1'b1, "break");
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0000);
    tx_busy <= 1'b1;
    @(posedge pclk);
    tx_busy <= 1'b0;
    @(posedge pclk);
    rs(8'hC0, 8'hFF);
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0002);
    rs(8'h80, 8'hFF);
    check(tx_enable, 1'b1, "txen");
    $display("transmit flags done");
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0010);
    lm.send(9'h003, 8, 1'b1, 1'b0);
    rs(8'h20, 8'h3F);
    apb(1'b0, USF_OFF_DATA, 32'h0000_0000);
    check(rd, 32'h0000_0003, "data");
    rs(8'h00, 8'h3F);
    lm.send(9'h001, 8, 1'b0, 1'b1);
    rs(8'h27, 8'h3F);
    lm.send(9'h002, 8, 1'b1, 1'b0);
    rs(8'h2F, 8'h3F);
    apb(1'b0, USF_OFF_DATA, 32'h0000_0000);
    check(rd, 32'h0000_0001, "kept");
    rs(8'h00, 8'h3F);
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0030);
    lm.send(9'h001, 8, 1'b1, 1'b0);
    rs(8'h20, 8'h3F);
    drain();
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0040);
    lm.send(9'h001, 8, 1'b0, 1'b0);
    rs(8'h00, 8'h3F);
    lm.send(9'h004, 8, 1'b1, 1'b0);
    apb(1'b0, USF_OFF_DATA, 32'h0000_0000);
    apb(1'b1, USF_OFF_CTRL, 32'h0000_0000);
    rs(8'h00, 8'h3F);
    lm.send(9'h005, 8, 1'b1, 1'b0);
    apb(1'b0, USF_OFF_DATA, 32'h0000_0000);
    rs(8'h20, 8'h3F);
    drain();
    $display("receive flags done");
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, USF_OFF_CTRL, (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'h0000_0008 : 32'h0000_0004);
      lm.send(9'h000, (k == 2) ? 9 : 8, 1'b1, 1'b0);
      lm.idle((k == 0) ? 8 : 9);
      rs(8'h20, 8'h3F);
      lm.idle(1);
      rs(8'h30, 8'h3F);
      apb(1'b0, USF_OFF_DATA, 32'h0000_0000);
      rs(8'h00, 8'h3F);
      lm.idle(12);
      rs(8'h00, 8'h3F);
    end
    check(ninth_bit_select, 1'b1, "ninth");
    $display("quiet line done");
    close_out();
  end
endmodule // test_usf_status_flags
